// file: sow_top.sv
// Sensor result readout, factory test codes and queue watermark logic

`timescale 1ns/100ps

module sow_top
#(
   parameter logic [7:0] RATE_X_CODE_INIT = 8'h00, // Arbitrary value
   parameter logic [7:0] RATE_Y_CODE_INIT = 8'h00, // Arbitrary value
   parameter logic [7:0] RATE_Z_CODE_INIT = 8'h00  // Arbitrary value
)
(
   input  wire logic                                mclk,
   input  wire logic                                rst,
   input  wire logic [7:0]                          reg_addr,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   input  wire logic [7:0]                          reg_wdata,
   output logic      [7:0]                          reg_rdata,
   input  wire logic                                fifo_data_read,
   input  wire logic                                fifo_burst_active,
   input  wire logic [sow_pkg::COUNT_WIDTH-1:0]     fifo_count,
   input  wire logic                                latch_mode,
   input  wire logic                                full_conditioning_reset,
   input  wire logic [1:0]                          rate_full_scale_select,
   input  wire logic                                sample_strobe,
   input  wire logic signed [sow_pkg::RESULT_WIDTH-1:0] accel_x_sample,
   input  wire logic signed [sow_pkg::RESULT_WIDTH-1:0] accel_y_sample,
   input  wire logic signed [sow_pkg::RESULT_WIDTH-1:0] accel_z_sample,
   input  wire logic signed [sow_pkg::RESULT_WIDTH-1:0] temperature_sample,
   input  wire logic signed [sow_pkg::RESULT_WIDTH-1:0] rate_x_sample,
   input  wire logic signed [sow_pkg::RESULT_WIDTH-1:0] rate_y_sample,
   input  wire logic signed [sow_pkg::RESULT_WIDTH-1:0] rate_z_sample,
   output logic                                     int_out,
   output logic                                     queue_level_flag,
   output logic                                     accel_path_reset,
   output logic                                     temp_path_reset,
   output logic                                     rate_path_reset
);
   import sow_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic signed [RESULT_WIDTH-1:0]  accel_x_result;
   logic signed [RESULT_WIDTH-1:0]  accel_y_result;
   logic signed [RESULT_WIDTH-1:0]  accel_z_result;
   logic signed [RESULT_WIDTH-1:0]  temperature_result;
   logic signed [RESULT_WIDTH-1:0]  rate_x_result;
   logic signed [RESULT_WIDTH-1:0]  rate_y_result;
   logic signed [RESULT_WIDTH-1:0]  rate_z_result;
   logic signed [RESULT_WIDTH-1:0]  rate_x_scaled;
   logic signed [RESULT_WIDTH-1:0]  rate_y_scaled;
   logic signed [RESULT_WIDTH-1:0]  rate_z_scaled;
   logic        [7:0]               rate_x_test_code;
   logic        [7:0]               rate_y_test_code;
   logic        [7:0]               rate_z_test_code;
   logic        [THRESHOLD_WIDTH-1:0] queue_level_threshold;
   logic        [1:0]               datapath_reset_bits;
   logic                            burst_read_seen;
   logic                            threshold_enabled;
   logic                            level_reached;
   logic                            watermark_set;
   logic                            first_burst_read;
   logic                            next_queue_level_flag;
   logic        [8:0]               pulse_count;
   logic                            write_path_reset;
   logic        [7:0]               next_reg_rdata;

   localparam logic [8:0] PULSE_LOAD = 9'(PULSE_CYCLES - 1);

   // ----------------------------------------------------------------
   // Result capture
   // ----------------------------------------------------------------

   // rate scaling
   // Finest range is the raw count; coarser ranges shift it down
   assign rate_x_scaled = rate_x_sample >>> rate_full_scale_select;
   assign rate_y_scaled = rate_y_sample >>> rate_full_scale_select;
   assign rate_z_scaled = rate_z_sample >>> rate_full_scale_select;

   // paired byte update
   // All seven words load on one edge, so a multi-byte read that
   // falls between two strobes sees one coherent sample.
   // clears sensor outputs
   always_ff @(posedge mclk)
   begin
      if (rst || full_conditioning_reset)
      begin
         accel_x_result     <= RESULT_RESET;
         accel_y_result     <= RESULT_RESET;
         accel_z_result     <= RESULT_RESET;
         temperature_result <= RESULT_RESET;
         rate_x_result      <= RESULT_RESET;
         rate_y_result      <= RESULT_RESET;
         rate_z_result      <= RESULT_RESET;
      end
      else if (sample_strobe)
      begin
         accel_x_result     <= accel_x_sample;
         accel_y_result     <= accel_y_sample;
         accel_z_result     <= accel_z_sample;
         temperature_result <= temperature_sample;
         rate_x_result      <= rate_x_scaled;
         rate_y_result      <= rate_y_scaled;
         rate_z_result      <= rate_z_scaled;
      end
   end

   // ----------------------------------------------------------------
   // Writable registers
   // ----------------------------------------------------------------

   // factory test codes
   // Loaded from parameters at reset, then freely rewritable
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rate_x_test_code <= RATE_X_CODE_INIT;
         rate_y_test_code <= RATE_Y_CODE_INIT;
         rate_z_test_code <= RATE_Z_CODE_INIT;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADDR_RATE_X_TEST_CODE)
            rate_x_test_code <= reg_wdata;
         if (reg_addr == ADDR_RATE_Y_TEST_CODE)
            rate_y_test_code <= reg_wdata;
         if (reg_addr == ADDR_RATE_Z_TEST_CODE)
            rate_z_test_code <= reg_wdata;
      end
   end

   // resets to zero
   // Upper register keeps only two bits; the rest is dropped
   always_ff @(posedge mclk)
   begin
      if (rst)
         queue_level_threshold <= THRESHOLD_RESET;
      else if (reg_wr && reg_addr == ADDR_THRESHOLD_UPPER)
         queue_level_threshold[9:8] <= reg_wdata[1:0];
      else if (reg_wr && reg_addr == ADDR_THRESHOLD_LOWER)
         queue_level_threshold[7:0] <= reg_wdata;
   end

   // reserved bits not stored
   // Only the two reset bits are held; they read back as written
   always_ff @(posedge mclk)
   begin
      if (rst)
         datapath_reset_bits <= DATAPATH_RESET_RESET;
      else if (write_path_reset)
         datapath_reset_bits <= reg_wdata[1:0];
   end

   assign write_path_reset = reg_wr && (reg_addr == ADDR_DATAPATH_RESET);

   // ----------------------------------------------------------------
   // Signal path resets
   // ----------------------------------------------------------------

   // full reset hits every path
   // One-cycle pulses; results are left alone by the per-path reset
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         accel_path_reset <= 1'b0;
         temp_path_reset  <= 1'b0;
         rate_path_reset  <= 1'b0;
      end
      else
      begin
         accel_path_reset <= full_conditioning_reset ||
                             (write_path_reset &&
                              reg_wdata[ACCEL_RESET_BIT]);
         temp_path_reset  <= full_conditioning_reset ||
                             (write_path_reset &&
                              reg_wdata[TEMP_RESET_BIT]);
         rate_path_reset  <= full_conditioning_reset;
      end
   end

   // ----------------------------------------------------------------
   // Watermark detection
   // ----------------------------------------------------------------

   assign threshold_enabled = (queue_level_threshold != THRESHOLD_RESET);

   assign level_reached =
      (fifo_count >= {{(COUNT_WIDTH-THRESHOLD_WIDTH){1'b0}},
                      queue_level_threshold});

   // re-arms after the burst
   // Blocking the set until the burst ends is what delays the
   // re-assertion to the end of the host read.
   assign watermark_set = threshold_enabled && level_reached &&
                          !fifo_burst_active && !queue_level_flag;

   // burst tracking
   // Remembers that this burst already had its first data read
   always_ff @(posedge mclk)
   begin
      if (rst)
         burst_read_seen <= 1'b0;
      else if (!fifo_burst_active)
         burst_read_seen <= 1'b0;
      else if (fifo_data_read)
         burst_read_seen <= 1'b1;
   end

   assign first_burst_read = fifo_data_read && !burst_read_seen;

   // cleared by data read
   // Set wins over clear so a fresh event is never dropped
   always_comb
   begin
      if (watermark_set)
         next_queue_level_flag = 1'b1;
      else if (first_burst_read)
         next_queue_level_flag = 1'b0;
      else
         next_queue_level_flag = queue_level_flag;
   end

   // status read has no effect on flag
   always_ff @(posedge mclk)
   begin
      if (rst)
         queue_level_flag <= 1'b0;
      else
         queue_level_flag <= next_queue_level_flag;
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------

   // pulse width counter
   // A data read does not cut a running pulse short
   always_ff @(posedge mclk)
   begin
      if (rst)
         pulse_count <= 9'h000;
      else if (watermark_set)
         pulse_count <= PULSE_LOAD;
      else if (pulse_count != 9'h000)
         pulse_count <= pulse_count - 9'h001;
   end

   // latch released with the flag
   // Latched output follows the flag on the same edge
   always_ff @(posedge mclk)
   begin
      if (rst)
         int_out <= 1'b0;
      else if (latch_mode)
         int_out <= next_queue_level_flag;
      else
         int_out <= watermark_set || (pulse_count != 9'h000);
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------

   // status bit position
   // Unmapped addresses read as zero
   always_comb
   begin
      next_reg_rdata = 8'h00;
      case (reg_addr)
         ADDR_QUEUE_STATUS:
            next_reg_rdata[QUEUE_FLAG_BIT] = queue_level_flag;
         ADDR_ACCEL_X_HIGH:     next_reg_rdata = accel_x_result[15:8];
         ADDR_ACCEL_X_LOW:      next_reg_rdata = accel_x_result[7:0];
         ADDR_ACCEL_Y_HIGH:     next_reg_rdata = accel_y_result[15:8];
         ADDR_ACCEL_Y_LOW:      next_reg_rdata = accel_y_result[7:0];
         ADDR_ACCEL_Z_HIGH:     next_reg_rdata = accel_z_result[15:8];
         ADDR_ACCEL_Z_LOW:      next_reg_rdata = accel_z_result[7:0];
         ADDR_TEMPERATURE_HIGH: next_reg_rdata = temperature_result[15:8];
         ADDR_TEMPERATURE_LOW:  next_reg_rdata = temperature_result[7:0];
         ADDR_RATE_X_HIGH:      next_reg_rdata = rate_x_result[15:8];
         ADDR_RATE_X_LOW:       next_reg_rdata = rate_x_result[7:0];
         ADDR_RATE_Y_HIGH:      next_reg_rdata = rate_y_result[15:8];
         ADDR_RATE_Y_LOW:       next_reg_rdata = rate_y_result[7:0];
         ADDR_RATE_Z_HIGH:      next_reg_rdata = rate_z_result[15:8];
         ADDR_RATE_Z_LOW:       next_reg_rdata = rate_z_result[7:0];
         ADDR_RATE_X_TEST_CODE: next_reg_rdata = rate_x_test_code;
         ADDR_RATE_Y_TEST_CODE: next_reg_rdata = rate_y_test_code;
         ADDR_RATE_Z_TEST_CODE: next_reg_rdata = rate_z_test_code;
         ADDR_THRESHOLD_UPPER:
            next_reg_rdata[1:0] = queue_level_threshold[9:8];
         ADDR_THRESHOLD_LOWER:
            next_reg_rdata = queue_level_threshold[7:0];
         ADDR_DATAPATH_RESET:
            next_reg_rdata[1:0] = datapath_reset_bits;
         default:               next_reg_rdata = 8'h00;
      endcase
   end

   // Read data is held until the next read strobe
   always_ff @(posedge mclk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= next_reg_rdata;
   end

endmodule // sow_top

// file: sow_pkg.sv
// Register map and constants of the sensor output and watermark block
package sow_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_QUEUE_STATUS      = 8'h39;
   localparam logic [7:0] ADDR_ACCEL_X_HIGH      = 8'h3B;
   localparam logic [7:0] ADDR_ACCEL_X_LOW       = 8'h3C;
   localparam logic [7:0] ADDR_ACCEL_Y_HIGH      = 8'h3D;
   localparam logic [7:0] ADDR_ACCEL_Y_LOW       = 8'h3E;
   localparam logic [7:0] ADDR_ACCEL_Z_HIGH      = 8'h3F;
   localparam logic [7:0] ADDR_ACCEL_Z_LOW       = 8'h40;
   localparam logic [7:0] ADDR_TEMPERATURE_HIGH  = 8'h41;
   localparam logic [7:0] ADDR_TEMPERATURE_LOW   = 8'h42;
   localparam logic [7:0] ADDR_RATE_X_HIGH       = 8'h43;
   localparam logic [7:0] ADDR_RATE_X_LOW        = 8'h44;
   localparam logic [7:0] ADDR_RATE_Y_HIGH       = 8'h45;
   localparam logic [7:0] ADDR_RATE_Y_LOW        = 8'h46;
   localparam logic [7:0] ADDR_RATE_Z_HIGH       = 8'h47;
   localparam logic [7:0] ADDR_RATE_Z_LOW        = 8'h48;
   localparam logic [7:0] ADDR_RATE_X_TEST_CODE  = 8'h50;
   localparam logic [7:0] ADDR_RATE_Y_TEST_CODE  = 8'h51;
   localparam logic [7:0] ADDR_RATE_Z_TEST_CODE  = 8'h52;
   localparam logic [7:0] ADDR_THRESHOLD_UPPER   = 8'h60;
   localparam logic [7:0] ADDR_THRESHOLD_LOWER   = 8'h61;
   localparam logic [7:0] ADDR_DATAPATH_RESET    = 8'h68;

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int QUEUE_FLAG_BIT    = 6;
   localparam int ACCEL_RESET_BIT   = 1;
   localparam int TEMP_RESET_BIT    = 0;
   localparam int THRESHOLD_WIDTH   = 10;
   localparam int RESULT_WIDTH      = 16;
   localparam int COUNT_WIDTH       = 16;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [9:0]  THRESHOLD_RESET      = 10'h000;
   localparam logic [1:0]  DATAPATH_RESET_RESET = 2'h0;
   localparam logic [15:0] RESULT_RESET         = 16'h0000;

   // ----------------------------------------------------------------
   // Scaling and timing
   // ----------------------------------------------------------------
   localparam int RATE_COUNTS_PER_DPS = 131;
   localparam int CLK_PERIOD_NS       = 100;
   localparam int PULSE_WIDTH_NS      = 50000;
   localparam int PULSE_CYCLES        = PULSE_WIDTH_NS / CLK_PERIOD_NS;

endpackage : sow_pkg

// file: sow_chk.sv
// Assertion checker of the sensor output and watermark block
`timescale 1ns/100ps
module sow_chk
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        fifo_data_read,
   input wire logic        fifo_burst_active,
   input wire logic [15:0] fifo_count,
   input wire logic        latch_mode,
   input wire logic        full_conditioning_reset,
   input wire logic        int_out,
   input wire logic        queue_level_flag,
   input wire logic        accel_path_reset,
   input wire logic        temp_path_reset,
   input wire logic        rate_path_reset
);
   logic [9:0]  th;     // Mirror of the threshold
   logic        seen;   // A queue read was seen in this burst
   logic [15:0] hi_cnt; // Cycles that int_out has stood high
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ------
   // Helpers
   // ------
   // Threshold mirror follows the host writes
   always_ff @(posedge mclk)
      if (rst)
         th <= 10'h000;
      else if (reg_wr && reg_addr == 8'h60)
         th[9:8] <= reg_wdata[1:0];
      else if (reg_wr && reg_addr == 8'h61)
         th[7:0] <= reg_wdata;
   // Burst tracking drops whenever the burst ends
   always_ff @(posedge mclk)
      if (rst || !fifo_burst_active)
         seen <= 1'b0;
      else if (fifo_data_read)
         seen <= 1'b1;
   // Counts only while high, so a fall shows the whole width
   always_ff @(posedge mclk)
      if (rst || !int_out)
         hi_cnt <= 16'h0000;
      else
         hi_cnt <= hi_cnt + 16'h0001;
   sequence s_pulse(sig);
      sig ##1 !sig;
   endsequence
   sequence s_set;
      th != 10'h000 && fifo_count >= {6'h00, th} && !fifo_burst_active
         && !queue_level_flag;
   endsequence
   AST_FLAG_SET: assert property (s_set |=> queue_level_flag)
      else $error("flag not set at threshold");
   AST_ZERO_OFF: assert property (
      th == 10'h000 && !queue_level_flag |=> !queue_level_flag)
      else $error("flag set with zero threshold");
   AST_BURST_HOLD: assert property (
      fifo_burst_active && !queue_level_flag |=> !queue_level_flag)
      else $error("flag set during burst");
   AST_FLAG_KEEP: assert property (
      queue_level_flag && !(fifo_data_read && !seen) |=> queue_level_flag)
      else $error("flag lost without first read");
   AST_FIRST_CLEAR: assert property (
      queue_level_flag && fifo_data_read && !seen |=> !queue_level_flag)
      else $error("first read kept flag");
   AST_INT_RISE: assert property ($rose(queue_level_flag) |-> int_out)
      else $error("flag without interrupt");
   AST_LATCH_CLR: assert property (
      latch_mode && $fell(queue_level_flag) |-> !int_out)
      else $error("latched interrupt kept");
   AST_PULSE_LEN: assert property (
      !latch_mode && $fell(int_out) |-> hi_cnt == 16'h01F4)
      else $error("pulse width wrong");
   AST_ACCEL_RST: assert property (
      reg_wr && reg_addr == 8'h68 && reg_wdata[1] |=>
         s_pulse(accel_path_reset))
      else $error("accel path reset pulse wrong");
   AST_TEMP_RST: assert property (
      reg_wr && reg_addr == 8'h68 && reg_wdata[0] |=> s_pulse(temp_path_reset))
      else $error("temp path reset pulse wrong");
   AST_FULL_RST: assert property (
      full_conditioning_reset |=>
         accel_path_reset && temp_path_reset && rate_path_reset)
      else $error("full reset missed a path");
endmodule // sow_chk

bind sow_top sow_chk u_chk
(
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .fifo_data_read(fifo_data_read),
   .fifo_burst_active(fifo_burst_active), .fifo_count(fifo_count),
   .latch_mode(latch_mode),
   .full_conditioning_reset(full_conditioning_reset),
   .int_out(int_out), .queue_level_flag(queue_level_flag),
   .accel_path_reset(accel_path_reset),
   .temp_path_reset(temp_path_reset), .rate_path_reset(rate_path_reset)
);

// file: sow_host.sv
// Host processor model driving the register strobes
`timescale 1ns/100ps
module sow_host
(
   input  wire logic       mclk,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata
);
   // Bus idles with both strobes low
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One-cycle write strobe, launched just after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
   endtask
   // temperature in degrees
   // Host side work; the device only hands over the raw code
   function automatic real temp_deg(input logic signed [15:0] code);
      return $itor(code) / 326.8 + 25.0;
   endfunction
   // factory test value from a stored code
   function automatic real test_value(input logic [7:0] code,
                                      input logic [1:0] fs);
      return (2620.0 / (2.0 ** fs)) * (1.01 ** ($itor(code) - 1.0));
   endfunction
   // Read data is registered, so it is taken after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk);
      #1;
      d = reg_rdata;
      reg_rd = 1'b0;
   endtask
endmodule // sow_host

// file: testbench.sv
// Self-checking testbench of the sensor output and watermark block
`timescale 1ns/100ps
module testbench;
   logic              mclk = 1'b0;
   logic              rst, latch, full_rst, strobe, qrd, burst;
   logic              int_out, flag, acc_rst, tmp_rst, rat_rst;
   logic       [1:0]  fs;
   logic       [15:0] count;
   logic       [7:0]  addr, wdata, rdata, d, v;
   logic              wr, rd;
   logic signed [15:0] samp [7];
   logic signed [15:0] held [7];
   int                n_fail = 0;
   int                checks = 0;
   int                th;
   always #50 mclk = ~mclk;
   sow_host u_host
   (
      .mclk(mclk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr),
      .reg_rd(rd), .reg_wdata(wdata)
   );
   sow_top u_dut
   (
      .mclk(mclk), .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
      .reg_wdata(wdata), .reg_rdata(rdata), .fifo_data_read(qrd),
      .fifo_burst_active(burst), .fifo_count(count), .latch_mode(latch),
      .full_conditioning_reset(full_rst), .rate_full_scale_select(fs),
      .sample_strobe(strobe), .accel_x_sample(samp[0]),
      .accel_y_sample(samp[1]), .accel_z_sample(samp[2]),
      .temperature_sample(samp[3]), .rate_x_sample(samp[4]),
      .rate_y_sample(samp[5]), .rate_z_sample(samp[6]),
      .int_out(int_out), .queue_level_flag(flag),
      .accel_path_reset(acc_rst), .temp_path_reset(tmp_rst),
      .rate_path_reset(rat_rst)
   );
   // ------
   // Helpers
   // ------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, d);
      chk(16'(d), 16'(e));
   endtask
   // First read of a new burst
   task automatic qread();
      burst = 1'b1;
      qrd = 1'b1;
      cyc(1);
      qrd = 1'b0;
   endtask
   // Expected byte; rate results shrink with the range select
   function automatic logic [7:0] exp_b(input logic [7:0] a);
      logic signed [15:0] s;
      s = held[(a - 8'h3B) >> 1];
      if (a >= 8'h43)
         s = s >>> fs;
      return a[0] ? s[15:8] : s[7:0];
   endfunction
   // Watchdog far beyond the roughly 700 cycles the run needs
   initial
   begin
      #(20000 * 100);
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end
   initial
   begin
      // Burst starts idle, or it would block every watermark set
      {rst, latch, full_rst, strobe, qrd, burst} = 6'h20;
      {fs, count} = 18'h00000;
      foreach (samp[i]) samp[i] = 16'h0000;
      void'($urandom(37737));
      cyc(5);
      rst = 1'b0;
      // Host keeps bit 7 of 0x1A clear
      u_host.wr(8'h1A, 8'h00);
      rdc(8'h60, 8'h00);
      rdc(8'h61, 8'h00);
      rdc(8'h39, 8'h00);
      $display("test reset done");
      // Every range select, with the most negative rate as corner
      for (int k = 0; k < 4; k++)
      begin
         fs = 2'(k);
         foreach (samp[i]) samp[i] = 16'($urandom);
         samp[4] = 16'h8000;
         strobe = 1'b1;
         cyc(1);
         strobe = 1'b0;
         held = samp;
         foreach (samp[i]) samp[i] = 16'($urandom);
         for (int a = 8'h3B; a <= 8'h48; a++)
            rdc(8'(a), exp_b(8'(a)));
      end
      u_host.wr(8'h3B, 8'h5A);
      rdc(8'h3B, exp_b(8'h3B));
      chk(16'(int'(u_host.temp_deg(16'sh0CC4))), 16'h0023);
      chk(16'(int'(u_host.test_value(8'h01, 2'h1))), 16'h051E);
      $display("test results done");
      for (int a = 8'h50; a <= 8'h52; a++)
      begin
         v = 8'($urandom);
         u_host.wr(8'(a), v);
         rdc(8'(a), v);
      end
      u_host.wr(8'h70, 8'hFF);
      rdc(8'h70, 8'h00);
      u_host.wr(8'h68, 8'hFC);
      rdc(8'h68, 8'h00);
      $display("test codes done");
      u_host.wr(8'h68, 8'h02);
      chk(16'({acc_rst, tmp_rst}), 16'h0002);
      rdc(8'h3C, exp_b(8'h3C));
      u_host.wr(8'h68, 8'h01);
      chk(16'({acc_rst, tmp_rst}), 16'h0001);
      rdc(8'h42, exp_b(8'h42));
      full_rst = 1'b1;
      cyc(1);
      full_rst = 1'b0;
      chk(16'({acc_rst, tmp_rst, rat_rst}), 16'h0007);
      rdc(8'h3B, 8'h00);
      rdc(8'h48, 8'h00);
      $display("test path resets done");
      th = 1 + ($urandom % 1023);
      latch = 1'b1;
      u_host.wr(8'h60, 8'(th >> 8));
      u_host.wr(8'h61, 8'(th));
      rdc(8'h60, 8'(th >> 8));
      rdc(8'h61, 8'(th));
      count = 16'(th - 1);
      cyc(3);
      chk(16'(flag), 16'h0000);
      count = 16'(th);
      cyc(1);
      chk(16'({flag, int_out}), 16'h0003);
      rdc(8'h39, 8'h40);
      chk(16'(flag), 16'h0001);
      qread();
      chk(16'({flag, int_out}), 16'h0000);
      cyc(1);
      qrd = 1'b1;
      cyc(1);
      qrd = 1'b0;
      cyc(2);
      chk(16'({flag, int_out}), 16'h0000);
      burst = 1'b0;
      cyc(2);
      chk(16'({flag, int_out}), 16'h0003);
      count = 16'h0000;
      qread();
      burst = 1'b0;
      cyc(3);
      chk(16'({flag, int_out}), 16'h0000);
      latch = 1'b0;
      count = 16'hFFFF;
      cyc(1);
      chk(16'({flag, int_out}), 16'h0003);
      cyc(499);
      chk(16'(int_out), 16'h0001);
      cyc(1);
      chk(16'({flag, int_out}), 16'h0002);
      count = 16'h0000;
      qread();
      burst = 1'b0;
      u_host.wr(8'h60, 8'h00);
      u_host.wr(8'h61, 8'h00);
      count = 16'hFFFF;
      cyc(5);
      chk(16'({flag, int_out}), 16'h0000);
      $display("test watermark done");
      complete_run();
   end
endmodule // testbench
